// ### crc_check_pkg.sv
// Functional notes
// RULE1: load and shift only on readout clock rise
// RULE2: select high shifts one bit per rise
// RULE3: select low parallel loads from chosen source
// RULE4: source 0 loads the precomputed value
// RULE5: source 1 loads the computed signature
// RULE6: source ignored while shifting
// RULE7: mismatch flag timed by engine clock
// RULE8: mismatch raised when signature differs
// RULE9: user routes mismatch flag to a pin
// RULE10: one bit per clock, 31 shifts
// RULE11: serial bits inverted, user complements them
// RULE12: signature kept in 32-bit register
// RULE13: engine clocked by divided oscillator, 1..256
// RULE14: readout clock matches engine rate; host runs it at a fixed 16-clk period regardless of the divider
// RULE15: user synchronises mismatch flag before use
`default_nettype none
package crc_check_pkg;
  // ----------------------------------------
  // register map, byte offsets
  // ----------------------------------------
  localparam logic [7:0] ctrl_off    = 8'h00;
  localparam logic [7:0] status_off  = 8'h04;
  localparam logic [7:0] mask_off    = 8'h08;
  localparam logic [7:0] precrc_off  = 8'h0c;
  localparam logic [7:0] sig_off     = 8'h10;
  localparam logic [7:0] memaddr_off = 8'h14;
  localparam logic [7:0] memdata_off = 8'h18;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int ctrl_en_bit   = 0;
  localparam int ctrl_div_lsb  = 8;
  localparam int stat_mis_bit  = 0;
  localparam int stat_pass_bit = 1;
  localparam int stat_w        = 2;
  localparam logic        ctrl_en_rst  = 1'b1;
  localparam logic [7:0]  ctrl_div_rst = 8'h00;
  localparam logic [31:0] precrc_rst   = 32'h0000_0000;
  // ----------------------------------------
  // engine
  // ----------------------------------------
  localparam int          word_w    = 32;
  localparam int          mem_depth = 8;
  localparam int          mem_aw    = 3;
  localparam logic [31:0] crc_poly  = 32'h04c1_1db7;
  localparam logic [31:0] crc_seed  = 32'hffff_ffff;
  // ----------------------------------------
  // readout timing
  // ----------------------------------------
  localparam int          clk_period_ns  = 100;
  localparam int          rd_half_ns     = 800;
  localparam int          rd_half_cyc    = (rd_half_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [4:0]  rd_half        = 5'(rd_half_cyc);
  localparam logic [5:0]  rd_bits        = 6'h20;
endpackage
`default_nettype wire

// ### crc_link_if.sv
`default_nettype none
interface crc_link_if;
  logic readout_clock;
  logic readout_shift_select;
  logic load_source;
  logic result_bit;
  logic crc_mismatch;
  modport device (
    input  readout_clock, readout_shift_select, load_source,
    output result_bit, crc_mismatch
  );
  modport host (
    output readout_clock, readout_shift_select, load_source,
    input  result_bit, crc_mismatch
  );
endinterface
`default_nettype wire

// ### error_check_engine.sv
// Local design decisions: the register offsets and strobed register access.
`default_nettype none
module error_check_engine (
  input  wire logic        clk,
  input  wire logic        arst_n,
  crc_link_if.device       link,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  output var  logic        irq
);
  // ----------------------------------------
  // crc of one word, msb first
  // ----------------------------------------
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      r = {r[30:0], 1'b0} ^ (crc_check_pkg::crc_poly & {32{r[31] ^ d[i]}});
    end
    return r;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic       rc_prev_r;
  logic       rc_rise;
  logic       sel_s;
  logic       src_s;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r      <= 3'h0;
      s2_r      <= 3'h0;
      rc_prev_r <= 1'b0;
    end
    else
    begin
      s1_r      <= {link.load_source, link.readout_shift_select, link.readout_clock};
      s2_r      <= s1_r;
      rc_prev_r <= s2_r[0];
    end
  end
  assign rc_rise = s2_r[0] & ~rc_prev_r;
  assign sel_s   = s2_r[1];
  assign src_s   = s2_r[2];

  // ----------------------------------------
  // registers and engine state
  // ----------------------------------------
  logic [31:0] mem_r [crc_check_pkg::mem_depth];
  logic [31:0] mem_nxt [crc_check_pkg::mem_depth];
  logic                                ctrl_en_r,  ctrl_en_nxt;
  logic [7:0]                          div_r,      div_nxt;
  logic [7:0]                          div_cnt_r,  div_cnt_nxt;
  logic [crc_check_pkg::stat_w-1:0]    status_r,   status_nxt;
  logic [crc_check_pkg::stat_w-1:0]    mask_r,     mask_nxt;
  logic [31:0]                         precrc_r,   precrc_nxt;
  logic [31:0]                         sig_r,      sig_nxt;
  logic [31:0]                         acc_r,      acc_nxt;
  logic [crc_check_pkg::mem_aw-1:0]    idx_r,      idx_nxt;
  logic [crc_check_pkg::mem_aw-1:0]    memaddr_r,  memaddr_nxt;
  logic                                mis_r,      mis_nxt;
  logic [31:0]                         sr_r,       sr_nxt;
  logic                                res_r,      res_nxt;
  logic [31:0]                         rdata_nxt;
  logic                                irq_nxt;
  logic                                tick;
  logic [31:0]                         acc_step;
  logic                                pass_end;
  logic [crc_check_pkg::stat_w-1:0]    ev;

  assign tick     = ctrl_en_r && (div_cnt_r == div_r); // RULE13
  assign acc_step = crc_word(acc_r, mem_r[idx_r]);
  assign pass_end = tick && (idx_r == crc_check_pkg::mem_aw'(crc_check_pkg::mem_depth - 1));

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    ctrl_en_nxt = ctrl_en_r;
    // hold every register except the divider counter, rdata, irq and res_r unless told otherwise
    div_nxt     = div_r;
    mask_nxt    = mask_r;
    precrc_nxt  = precrc_r;
    memaddr_nxt = memaddr_r;
    mem_nxt     = mem_r;
    div_cnt_nxt = tick ? 8'h00 : (ctrl_en_r ? div_cnt_r + 8'h01 : 8'h00);
    acc_nxt     = acc_r;
    idx_nxt     = idx_r;
    sig_nxt     = sig_r;
    mis_nxt     = mis_r;
    ev          = '0;
    if (tick)
    begin
      acc_nxt = pass_end ? crc_check_pkg::crc_seed : acc_step;
      idx_nxt = idx_r + 1'b1;
      if (pass_end)
      begin
        sig_nxt = acc_step; // RULE12
        mis_nxt = (acc_step != precrc_r); // RULE8 RULE7
        ev[crc_check_pkg::stat_pass_bit] = 1'b1;
        ev[crc_check_pkg::stat_mis_bit]  = (acc_step != precrc_r) && !mis_r;
      end
    end
    status_nxt = status_r;
    if (wr)
    begin
      unique case (addr)
        crc_check_pkg::ctrl_off:
        begin
          ctrl_en_nxt = wdata[crc_check_pkg::ctrl_en_bit];
          div_nxt     = wdata[crc_check_pkg::ctrl_div_lsb +: 8];
        end
        crc_check_pkg::status_off:  status_nxt  = status_r & ~wdata[crc_check_pkg::stat_w-1:0];
        crc_check_pkg::mask_off:    mask_nxt    = wdata[crc_check_pkg::stat_w-1:0];
        crc_check_pkg::precrc_off:  precrc_nxt  = wdata;
        crc_check_pkg::memaddr_off: memaddr_nxt = wdata[crc_check_pkg::mem_aw-1:0];
        crc_check_pkg::memdata_off: mem_nxt[memaddr_r] = wdata;
        default:                    ctrl_en_nxt = ctrl_en_r;
      endcase
    end
    status_nxt = status_nxt | ev;
    irq_nxt    = |(status_nxt & mask_nxt);
    rdata_nxt  = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        crc_check_pkg::ctrl_off:    rdata_nxt = {16'h0000, div_r, 7'h00, ctrl_en_r};
        crc_check_pkg::status_off:  rdata_nxt = 32'(status_r);
        crc_check_pkg::mask_off:    rdata_nxt = 32'(mask_r);
        crc_check_pkg::precrc_off:  rdata_nxt = precrc_r;
        crc_check_pkg::sig_off:     rdata_nxt = sig_r;
        crc_check_pkg::memaddr_off: rdata_nxt = 32'(memaddr_r);
        crc_check_pkg::memdata_off: rdata_nxt = mem_r[memaddr_r];
        default:                    rdata_nxt = 32'h0000_0000;
      endcase
    end
    // readout shift register
    sr_nxt = sr_r;
    if (rc_rise) // RULE1
    begin
      if (sel_s)
        sr_nxt = {sr_r[30:0], 1'b0}; // RULE2 RULE6 RULE10
      else if (src_s)
        sr_nxt = sig_r; // RULE3 RULE5
      else
        sr_nxt = precrc_r; // RULE4
    end
    res_nxt = ~sr_nxt[31]; // RULE11
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_en_r <= crc_check_pkg::ctrl_en_rst;
      div_r     <= crc_check_pkg::ctrl_div_rst;
      div_cnt_r <= 8'h00;
      status_r  <= '0;
      mask_r    <= '0;
      precrc_r  <= crc_check_pkg::precrc_rst;
      sig_r     <= 32'h0000_0000;
      acc_r     <= crc_check_pkg::crc_seed;
      idx_r     <= '0;
      memaddr_r <= '0;
      mis_r     <= 1'b0;
      sr_r      <= 32'h0000_0000;
      res_r     <= 1'b1;
      rdata     <= 32'h0000_0000;
      irq       <= 1'b0;
      for (int i = 0; i < crc_check_pkg::mem_depth; i++)
      begin
        mem_r[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      ctrl_en_r <= ctrl_en_nxt;
      div_r     <= div_nxt;
      div_cnt_r <= div_cnt_nxt;
      status_r  <= status_nxt;
      mask_r    <= mask_nxt;
      precrc_r  <= precrc_nxt;
      sig_r     <= sig_nxt;
      acc_r     <= acc_nxt;
      idx_r     <= idx_nxt;
      memaddr_r <= memaddr_nxt;
      mis_r     <= mis_nxt;
      sr_r      <= sr_nxt;
      res_r     <= res_nxt;
      rdata     <= rdata_nxt;
      irq       <= irq_nxt;
      mem_r     <= mem_nxt;
    end
  end

  assign link.result_bit   = res_r;
  assign link.crc_mismatch = mis_r; // RULE7
endmodule // error_check_engine
`default_nettype wire

// ### crc_readout_host.sv
`default_nettype none
module crc_readout_host (
  input  wire logic        clk,
  input  wire logic        arst_n,
  crc_link_if.host         link,
  input  wire logic        start,
  input  wire logic        source_sel,
  output var  logic        busy,
  output var  logic        done,
  output var  logic [31:0] value,
  output var  logic        mismatch_seen
);
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_run  = 1'b1
  } host_state_t;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
    end
    else
    begin
      s1_r <= {link.crc_mismatch, link.result_bit};
      s2_r <= s1_r; // RULE15
    end
  end

  // ----------------------------------------
  // readout sequencer
  // ----------------------------------------
  host_state_t st_r,    st_nxt;
  logic [4:0]  ph_r,    ph_nxt;
  logic [5:0]  edge_r,  edge_nxt;
  logic        rclk_r,  rclk_nxt;
  logic        sel_r,   sel_nxt;
  logic        src_r,   src_nxt;
  logic [31:0] val_nxt;
  logic        done_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    ph_nxt   = ph_r;
    edge_nxt = edge_r;
    rclk_nxt = rclk_r;
    sel_nxt  = sel_r;
    src_nxt  = src_r;
    val_nxt  = value;
    done_nxt = 1'b0;
    unique case (st_r)
      st_idle:
      begin
        if (start)
        begin
          st_nxt   = st_run;
          ph_nxt   = 5'h00;
          edge_nxt = 6'h00;
          sel_nxt  = 1'b0;
          src_nxt  = source_sel;
        end
      end
      st_run:
      begin
        ph_nxt = ph_r + 5'h01;
        if (ph_r == crc_check_pkg::rd_half - 5'h01)
        begin
          if (edge_r != 6'h00)
            val_nxt = {value[30:0], ~s2_r[0]}; // RULE11
          if (edge_r == crc_check_pkg::rd_bits)
          begin
            st_nxt   = st_idle;
            done_nxt = 1'b1;
          end
          else
          begin
            rclk_nxt = 1'b1;
            edge_nxt = edge_r + 6'h01;
          end
        end
        else if (ph_r == 5'((2 * crc_check_pkg::rd_half_cyc) - 1))
        begin
          rclk_nxt = 1'b0;
          ph_nxt   = 5'h00;
          sel_nxt  = 1'b1; // RULE10 RULE14
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r          <= st_idle;
      ph_r          <= 5'h00;
      edge_r        <= 6'h00;
      rclk_r        <= 1'b0;
      sel_r         <= 1'b0;
      src_r         <= 1'b0;
      value         <= 32'h0000_0000;
      done          <= 1'b0;
      busy          <= 1'b0;
      mismatch_seen <= 1'b0;
    end
    else
    begin
      st_r          <= st_nxt;
      ph_r          <= ph_nxt;
      edge_r        <= edge_nxt;
      rclk_r        <= rclk_nxt;
      sel_r         <= sel_nxt;
      src_r         <= src_nxt;
      value         <= val_nxt;
      done          <= done_nxt;
      busy          <= (st_nxt == st_run);
      mismatch_seen <= s2_r[1]; // RULE9
    end
  end

  assign link.readout_clock        = rclk_r;
  assign link.readout_shift_select = sel_r;
  assign link.load_source          = src_r;
endmodule // crc_readout_host
`default_nettype wire

// ### crc_check_props.sv
`default_nettype none
module crc_check_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic readout_clock,
  input wire logic readout_shift_select,
  input wire logic load_source,
  input wire logic result_bit,
  input wire logic crc_mismatch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // shifts seen since the last load, 31 = idle
  // ----------------------------------------
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       rck_r;
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (readout_clock && !rck_r)
      cnt_nxt = readout_shift_select ? cnt_r + 5'h01 : 5'h00;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= 5'h1f;
      rck_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      rck_r <= readout_clock;
    end
  end
  property p_upd_win;
    $changed(result_bit) |-> $past(readout_clock, 2) && !$past(readout_clock, 6);
  endproperty
  property p_hold;
    $rose(readout_clock) |=> $stable(result_bit)[*2];
  endproperty
  property p_hi;
    $rose(readout_clock) |-> readout_clock[*8];
  endproperty
  property p_lo;
    $fell(readout_clock) |-> !readout_clock[*8];
  endproperty
  property p_sel_stable;
    $rose(readout_clock) |-> ($stable(readout_shift_select) && $stable(load_source))[*4];
  endproperty
  property p_sel_low;
    ($changed(readout_shift_select) || $changed(load_source)) |-> !readout_clock;
  endproperty
  property p_shift_cnt;
    $rose(readout_clock) && readout_shift_select |-> cnt_r < 5'h1f;
  endproperty
  property p_load_full;
    $rose(readout_clock) && !readout_shift_select |-> cnt_r == 5'h1f;
  endproperty
  a_upd_win: assert property (p_upd_win) else $error("result bit moved off a readout edge");
  a_hold: assert property (p_hold) else $error("result bit moved too early");
  a_hi: assert property (p_hi) else $error("readout clock high too short");
  a_lo: assert property (p_lo) else $error("readout clock low too short");
  a_sel_stable: assert property (p_sel_stable) else $error("select moved near edge");
  a_sel_low: assert property (p_sel_low) else $error("select moved while clock high");
  a_shift_cnt: assert property (p_shift_cnt) else $error("more than 31 shifts");
  a_load_full: assert property (p_load_full) else $error("load before 31 shifts");
  c_load_pre: cover property ($rose(readout_clock) && !readout_shift_select && !load_source);
  c_load_sig: cover property ($rose(readout_clock) && !readout_shift_select && load_source);
  c_mis: cover property ($rose(crc_mismatch));
endmodule // crc_check_props
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, arst_n, wr, rd, irq, start, source_sel, busy, done, mismatch_seen;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, value, wire_sh, rv, good, pre, mem_m [8];
  int          n_errors, comparisons;
  crc_link_if link ();
  error_check_engine u_error_check_engine (.clk(clk), .arst_n(arst_n), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  crc_readout_host u_crc_readout_host (.clk(clk), .arst_n(arst_n), .link(link), .start(start),
    .source_sel(source_sel), .busy(busy), .done(done), .value(value),
    .mismatch_seen(mismatch_seen));
  crc_check_props u_crc_check_props (.clk(clk), .arst_n(arst_n),
    .readout_clock(link.readout_clock), .readout_shift_select(link.readout_shift_select),
    .load_source(link.load_source), .result_bit(link.result_bit),
    .crc_mismatch(link.crc_mismatch));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // wire monitor and bench model
  // ----------------------------------------
  always @(negedge link.readout_clock) wire_sh <= {wire_sh[30:0], ~link.result_bit};
  function automatic logic [31:0] crc_of();
    logic [31:0] c;
    c = crc_check_pkg::crc_seed;
    for (int w = 0; w < 8; w++)
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ mem_m[w][b]) ? crc_check_pkg::crc_poly : 32'h0);
    return c;
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic readout(input logic src, input logic [31:0] exp);
    @(posedge clk);
    start <= 1'b1;
    source_sel <= src;
    @(posedge clk);
    start <= 1'b0;
    #1 chk("busy", 32'h1, {31'h0, busy});
    for (int i = 0; i < 2000 && done !== 1'b1; i++)
      @(posedge clk) #1;
    chk("done", 32'h1, {31'h0, done});
    chk("idle", 32'h0, {31'h0, busy});
    chk("value", exp, value);
    chk("wire", exp, wire_sh);
  endtask
  task automatic flags(input logic m, input logic q);
    repeat (40) @(posedge clk);
    #1 chk("flag", {31'h0, m}, {31'h0, link.crc_mismatch});
    chk("seen", {31'h0, m}, {31'h0, mismatch_seen});
    chk("irq", {31'h0, q}, {31'h0, irq});
  endtask
  task automatic test_done();
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    test_done();
  end
  initial
  begin
    {arst_n, wr, rd, start, source_sel, addr, wdata} = '0;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(23080));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    bus_rd(crc_check_pkg::ctrl_off, rv);
    chk("ctrl", 32'h0000_0001, rv);
    bus_rd(crc_check_pkg::precrc_off, rv);
    chk("precrc", 32'h0, rv);
    bus_rd(8'h1c, rv);
    chk("unmapped", 32'h0, rv);
    for (int i = 0; i < 8; i++)
    begin
      mem_m[i] = $urandom;
      bus_wr(crc_check_pkg::memaddr_off, 32'(i));
      bus_wr(crc_check_pkg::memdata_off, mem_m[i]);
    end
    good = crc_of();
    pre = good ^ ($urandom | 32'h1);
    bus_wr(crc_check_pkg::precrc_off, pre);
    flags(1'b1, 1'b0);
    readout(1'b0, pre);
    readout(1'b1, good);
    bus_wr(crc_check_pkg::precrc_off, good);
    bus_wr(crc_check_pkg::sig_off, ~good);
    flags(1'b0, 1'b0);
    bus_rd(crc_check_pkg::sig_off, rv);
    chk("sig", good, rv);
    @(posedge clk) #1 chk("rdata_idle", 32'h0, rdata);
    bus_wr(crc_check_pkg::status_off, 32'h3);
    bus_rd(crc_check_pkg::status_off, rv);
    chk("status", 32'h0, rv & 32'h1);
    bus_wr(crc_check_pkg::mask_off, 32'h1);
    mem_m[3] = mem_m[3] ^ (32'h1 << ($urandom % 32));
    bus_wr(crc_check_pkg::memaddr_off, 32'h3);
    bus_wr(crc_check_pkg::memdata_off, mem_m[3]);
    flags(1'b1, 1'b1);
    bus_rd(crc_check_pkg::status_off, rv);
    chk("status", 32'h1, rv & 32'h1);
    bus_wr(crc_check_pkg::mask_off, 32'h0);
    flags(1'b1, 1'b0);
    bus_wr(crc_check_pkg::mask_off, 32'h1);
    bus_wr(crc_check_pkg::status_off, 32'h1);
    flags(1'b1, 1'b0);
    readout(1'b1, crc_of());
    readout(1'b0, good);
    bus_wr(crc_check_pkg::ctrl_off, 32'h0);
    mem_m[3] = mem_m[3] ^ 32'hffff_ffff;
    bus_wr(crc_check_pkg::memdata_off, mem_m[3]);
    flags(1'b1, 1'b0);
    bus_wr(crc_check_pkg::ctrl_off, 32'h0000_0301);
    repeat (100) @(posedge clk);
    bus_rd(crc_check_pkg::sig_off, rv);
    chk("sig_div", crc_of(), rv);
    test_done();
  end
endmodule // tb
`default_nettype wire
